/* File: rtl/pmirq_defs.svh */
// Constants for the identification and interrupt register block
// Notes on behaviour
// - 12-bit part code split across ID registers
// - Revision bits 7:6, variant bits 5:4
// - Status register at 02h, resets to zero
// - Bit 7 sets on rail or critical fault
// - Bit 3 sets on output shutdown
// - Bit 3 holds while any cause bit set
// - Bit 0 sets on upward hot crossing
// - Flags stay until host writes one
// - Mask register at 03h, resets all ones
// - Mask bits 7,3,0; one suppresses source
// - Cause bit set also sets shutdown flag
`ifndef PMIRQ_DEFS_SVH
`define PMIRQ_DEFS_SVH
`define PMIRQ_OFS_ID_LOW 8'h00
`define PMIRQ_OFS_ID_HIGH 8'h01
`define PMIRQ_OFS_FLAGS 8'h02
`define PMIRQ_OFS_MASK 8'h03
`define PMIRQ_FLAGS_RESET 8'h00
`define PMIRQ_MASK_RESET 8'hff
`define PMIRQ_IMPL_BITS 8'h89
`define PMIRQ_BIT_FAULT 7
`define PMIRQ_BIT_SHUTDOWN 3
`define PMIRQ_BIT_HOT 0
`define PMIRQ_PART_CODE 12'h5a3
`define PMIRQ_SILICON_REV 2'h0
`define PMIRQ_VARIANT 2'h0
`endif

/* File: rtl/pmirq_pkg.sv */
// Types for the identification and interrupt register block
package pmirq_pkg;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pmirq_req_t;
  typedef struct packed {
    logic rail_fault;
    logic temp_critical;
    logic shutdown;
    logic temp_hot;
    logic cause_pending;
    logic cause_set;
  } pmirq_evt_t;
endpackage : pmirq_pkg

/* File: rtl/pmirq_regs.sv */
// Identification, interrupt status and mask registers
`timescale 1ns/1ps
`include "pmirq_defs.svh"
module pmirq_regs #(
  parameter logic [11:0] PART_CODE = `PMIRQ_PART_CODE, // Arbitrary value
  parameter logic [1:0] SILICON_REV = `PMIRQ_SILICON_REV, // Arbitrary value
  parameter logic [1:0] VARIANT = `PMIRQ_VARIANT
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire pmirq_pkg::pmirq_req_t req_i,
  input wire pmirq_pkg::pmirq_evt_t evt_i,
  output logic [7:0] rdata_o,
  output logic irq_o
);
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic [7:0] mask_r;
  logic [7:0] mask_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic irq_r;
  logic irq_nxt;
  logic hot_prev_r;
  logic hot_prev_nxt;

  function automatic logic hit(input pmirq_pkg::pmirq_req_t r, input logic [7:0] ofs);
    hit = r.addr == ofs;
  endfunction : hit

  always_comb begin
    logic [7:0] set_v;
    logic [7:0] clr_v;
    set_v = '0;
    clr_v = '0;
    set_v[`PMIRQ_BIT_FAULT] = evt_i.rail_fault | evt_i.temp_critical;
    set_v[`PMIRQ_BIT_SHUTDOWN] = evt_i.shutdown | evt_i.cause_set;
    set_v[`PMIRQ_BIT_HOT] = evt_i.temp_hot & ~hot_prev_r;
    if (req_i.wr && hit(req_i, `PMIRQ_OFS_FLAGS)) begin
      clr_v = req_i.wdata & `PMIRQ_IMPL_BITS;
    end
    if (evt_i.cause_pending) begin
      clr_v[`PMIRQ_BIT_SHUTDOWN] = 1'b0;
    end
    flags_nxt = ((flags_r & ~clr_v) | set_v) & `PMIRQ_IMPL_BITS;
    mask_nxt = mask_r;
    if (req_i.wr && hit(req_i, `PMIRQ_OFS_MASK)) begin
      mask_nxt = (req_i.wdata & `PMIRQ_IMPL_BITS) | ~`PMIRQ_IMPL_BITS;
    end
    hot_prev_nxt = evt_i.temp_hot;
    irq_nxt = |(flags_nxt & ~mask_nxt & `PMIRQ_IMPL_BITS);
    rdata_nxt = rdata_r;
    if (req_i.rd) begin
      unique case (req_i.addr)
        `PMIRQ_OFS_ID_LOW: rdata_nxt = PART_CODE[7:0];
        `PMIRQ_OFS_ID_HIGH: rdata_nxt = {SILICON_REV, VARIANT, PART_CODE[11:8]};
        `PMIRQ_OFS_FLAGS: rdata_nxt = flags_r;
        `PMIRQ_OFS_MASK: rdata_nxt = mask_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_r <= `PMIRQ_FLAGS_RESET;
      mask_r <= `PMIRQ_MASK_RESET;
      rdata_r <= 8'h00;
      irq_r <= 1'b0;
      hot_prev_r <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      mask_r <= mask_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
      hot_prev_r <= hot_prev_nxt;
    end
  end

  assign rdata_o = rdata_r;
  assign irq_o = irq_r;

  a_flags_reset_zero: assert property (@(posedge clock_i) $rose(rst_n_i) |-> $past(flags_r) == 8'h00)
    else $error("status not zero after reset");
  a_mask_reset_ones: assert property (@(posedge clock_i) $rose(rst_n_i) |-> $past(mask_r) == 8'hff)
    else $error("mask not ones after reset");
  a_fault_sets: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (evt_i.rail_fault | evt_i.temp_critical) |=> flags_r[7])
    else $error("fault flag missed");
  a_shutdown_sets: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (evt_i.shutdown | evt_i.cause_set) |=> flags_r[3])
    else $error("shutdown flag missed");
  a_shutdown_held: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (flags_r[3] && evt_i.cause_pending) |=> flags_r[3])
    else $error("shutdown flag cleared with cause pending");
  a_hot_edge: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (evt_i.temp_hot && !hot_prev_r) |=> flags_r[0])
    else $error("hot flag missed");
  a_flags_sticky: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (flags_r[`PMIRQ_BIT_FAULT] && !(req_i.wr && hit(req_i, `PMIRQ_OFS_FLAGS) && req_i.wdata[`PMIRQ_BIT_FAULT]))
    |=> flags_r[`PMIRQ_BIT_FAULT])
    else $error("fault flag lost without clear");
  a_irq_follows: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    irq_o == |(flags_r & ~mask_r & `PMIRQ_IMPL_BITS))
    else $error("interrupt output wrong");
  a_reserved_zero: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (flags_r & ~`PMIRQ_IMPL_BITS) == `PMIRQ_FLAGS_RESET && (mask_r & ~`PMIRQ_IMPL_BITS) == ~`PMIRQ_IMPL_BITS)
    else $error("reserved bits changed");
  c_irq_raise: cover property (@(posedge clock_i) disable iff (!rst_n_i) $rose(irq_o));
  c_flag_clear: cover property (@(posedge clock_i) disable iff (!rst_n_i) $fell(flags_r[0]));
  c_shut_blocked: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    flags_r[`PMIRQ_BIT_SHUTDOWN] && evt_i.cause_pending && req_i.wr && hit(req_i, `PMIRQ_OFS_FLAGS)
    && req_i.wdata[`PMIRQ_BIT_SHUTDOWN]);
  c_id_read: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    req_i.rd && hit(req_i, `PMIRQ_OFS_ID_HIGH));

  // Read path checks
  a_read_id_low: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (req_i.rd && hit(req_i, `PMIRQ_OFS_ID_LOW)) |=> rdata_o == PART_CODE[7:0])
    else $error("low code byte wrong");
  a_read_id_high: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (req_i.rd && hit(req_i, `PMIRQ_OFS_ID_HIGH)) |=> rdata_o == {SILICON_REV, VARIANT, PART_CODE[11:8]})
    else $error("high code byte wrong");
  a_read_flags: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (req_i.rd && hit(req_i, `PMIRQ_OFS_FLAGS)) |=> rdata_o == $past(flags_r))
    else $error("status read wrong");
  a_read_mask: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (req_i.rd && hit(req_i, `PMIRQ_OFS_MASK)) |=> rdata_o == $past(mask_r))
    else $error("mask read wrong");
  a_rdata_holds: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !req_i.rd |=> $stable(rdata_o))
    else $error("read data changed without read");

  // Write path and hot edge checks
  a_mask_write: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (req_i.wr && hit(req_i, `PMIRQ_OFS_MASK)) |=> mask_r == ($past(req_i.wdata) | ~`PMIRQ_IMPL_BITS))
    else $error("mask write wrong");
  a_hot_clears: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (req_i.wr && hit(req_i, `PMIRQ_OFS_FLAGS) && req_i.wdata[`PMIRQ_BIT_HOT] && !(evt_i.temp_hot && !hot_prev_r))
    |=> !flags_r[`PMIRQ_BIT_HOT])
    else $error("hot flag not cleared");
  a_fault_clears: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (req_i.wr && hit(req_i, `PMIRQ_OFS_FLAGS) && req_i.wdata[`PMIRQ_BIT_FAULT]
    && !evt_i.rail_fault && !evt_i.temp_critical) |=> !flags_r[`PMIRQ_BIT_FAULT])
    else $error("fault flag not cleared");
  a_shutdown_clears: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (req_i.wr && hit(req_i, `PMIRQ_OFS_FLAGS) && req_i.wdata[`PMIRQ_BIT_SHUTDOWN] && !evt_i.cause_pending
    && !evt_i.shutdown && !evt_i.cause_set) |=> !flags_r[`PMIRQ_BIT_SHUTDOWN])
    else $error("shutdown flag not cleared");
  a_hot_no_level: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (!flags_r[`PMIRQ_BIT_HOT] && hot_prev_r) |=> !flags_r[`PMIRQ_BIT_HOT])
    else $error("hot flag set without rising edge");
endmodule : pmirq_regs

/* File: testbench/pmirq_host.sv */
// Host model issuing single-byte register accesses
`timescale 1ns/1ps
module pmirq_host (
  input wire logic clock_i,
  output pmirq_pkg::pmirq_req_t req_o
);
  initial req_o = '0;
  // Called at a falling edge; holds one cycle, then drops rd and wr and drives inverted address and data for one more cycle
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    req_o = {~w, w, a, d};
    @(negedge clock_i);
    req_o = {2'h0, ~a, ~d};
    @(negedge clock_i);
  endtask : access
endmodule : pmirq_host

/* File: testbench/test_pmirq_regs.sv */
// Self-checking bench for the identification and interrupt registers
`timescale 1ns/1ps
module test_pmirq_regs;
  localparam logic [11:0] PC = 12'h3c7; // Arbitrary value
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic irq;
  logic hp = 1'b0;
  logic [7:0] rdata, r, fl = 8'h00, mk = 8'hff;
  logic [31:0] seed = 32'hce8a;
  logic [7:0] adr[5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'hb2};
  int fails = 0;
  int samples_checked = 0;
  pmirq_pkg::pmirq_req_t req;
  pmirq_pkg::pmirq_evt_t ev = '0;
  always #25 clock_i = ~clock_i;
  pmirq_host u_pmirq_host (.clock_i(clock_i), .req_o(req));
  pmirq_regs #(.PART_CODE(PC), .SILICON_REV(2'h2), .VARIANT(2'h1)) u_pmirq_regs (.clock_i(clock_i),
    .rst_n_i(rst_n_i), .req_i(req), .evt_i(ev), .rdata_o(rdata), .irq_o(irq));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xs
  function automatic logic [7:0] upd(input logic [7:0] clr);
    clr = clr & 8'h89 & ~{4'h0, ev.cause_pending, 3'h0};
    return (fl & ~clr) | {ev.rail_fault | ev.temp_critical, 3'h0, ev.shutdown | ev.cause_set, 2'h0, ev.temp_hot & ~hp};
  endfunction : upd
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic step(input logic w, input logic [7:0] a, input logic [7:0] d);
    r = (a == 8'h00) ? PC[7:0] : (a == 8'h01) ? {4'h9, PC[11:8]} : (a == 8'h02) ? fl : (a == 8'h03) ? mk : 8'h00;
    u_pmirq_host.access(w, a, d);
    fl = upd((w && a == 8'h02) ? d : 8'h00);
    hp = ev.temp_hot;
    if (w && a == 8'h03) mk = d | 8'h76;
    if (!w) chk("read data", r, rdata);
    chk("irq", {7'h0, |(fl & ~mk & 8'h89)}, {7'h0, irq});
  endtask : step
  task automatic stop_test;
    $display("Checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    #200000;
    fails++;
    stop_test();
  end
  initial begin
    repeat (8) @(negedge clock_i);
    rst_n_i = 1'b1;
    @(negedge clock_i);
    foreach (adr[i]) step(1'b0, adr[i], 8'h00);
    $display("Reset values test done");
    step(1'b1, 8'h03, 8'h00);
    ev = 6'h0a;
    step(1'b1, 8'h02, 8'hff);
    ev = 6'h02;
    step(1'b1, 8'h02, 8'h08);
    ev = 6'h00;
    step(1'b1, 8'h02, 8'h08);
    step(1'b0, 8'h02, 8'h00);
    $display("Shutdown clear test done");
    for (int i = 0; i < 400; i++) begin
      seed = xs(seed);
      ev = seed[5:0];
      step(seed[8], adr[seed[11:9] % 5], seed[19:12]);
    end
    $display("Random traffic test done");
    stop_test();
  end
endmodule : test_pmirq_regs
